// ==== include/csd_pkg.sv ====
// constants and types for the channel select and sinc3 decimation block
// assumes one 20 MHz clock and a byte-wide register port
package csd_pkg;
  // ---------------------------------------------------------------------------
  // sizes and clocking
  // ---------------------------------------------------------------------------
  localparam int NCH = 8;
  localparam int DW = 24;
  localparam int ACC_W = 40;
  localparam int FIFO_DEPTH = 16;
  localparam int CLK_HZ = 20_000_000;
  localparam int OSC_HZ = 2_048_000;
  localparam int MOD_DIV = 2;
  localparam int MOD_HZ = CLK_HZ / MOD_DIV;
  localparam logic [3:0] RATIO_LOG2_BASE = 4'h6;
  localparam logic [1:0] SETTLE_PERIODS = 2'h3;
  localparam int TEST_DIV_SLOW = 2097152;
  localparam int TEST_DIV_FAST = 1048576;

  // ---------------------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------------------
  localparam logic [4:0] ADDR_CHSET0 = 5'h00;
  localparam logic [4:0] ADDR_CFG_A = 5'h08;
  localparam logic [4:0] ADDR_CFG_B = 5'h09;
  localparam logic [4:0] ADDR_CFG_C = 5'h0a;
  localparam logic [4:0] ADDR_STATUS = 5'h0b;

  // ---------------------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------------------
  localparam int CH_SEL_LSB = 0;
  localparam int CH_GAIN_LSB = 4;
  localparam int CFGB_AMP_BIT = 2;
  localparam int CFGC_REFPD_BIT = 7;
  localparam int CFGC_BIASM_BIT = 4;
  localparam int ST_SETTLED_BIT = 0;
  localparam int ST_RATEINV_BIT = 1;
  localparam int ST_OVERRUN_BIT = 2;
  localparam int ST_EMPTY_BIT = 3;
  localparam int ST_FULL_BIT = 4;
  localparam logic [7:0] CHSET_RST = 8'h00;
  localparam logic [2:0] RATE_RST = 3'h6;
  localparam logic [2:0] TCFG_RST = 3'h0;
  localparam logic REFPD_RST = 1'b1;
  localparam logic BIASM_RST = 1'b0;

  // ---------------------------------------------------------------------------
  // codes
  // ---------------------------------------------------------------------------
  localparam logic [2:0] SEL_NORMAL = 3'h0;
  localparam logic [2:0] SEL_SHORT = 3'h1;
  localparam logic [2:0] SEL_BIAS_MEASURE_ENABLE = 3'h2;
  localparam logic [2:0] SEL_SUPPLY = 3'h3;
  localparam logic [2:0] SEL_TEMP = 3'h4;
  localparam logic [2:0] SEL_TEST = 3'h5;
  localparam logic [2:0] SEL_BIAS_POS = 3'h6;
  localparam logic [2:0] SEL_BIAS_NEG = 3'h7;
  localparam logic [2:0] GAIN_INVALID = 3'h7;
  localparam logic [2:0] RATE_INVALID = 3'h7;
  localparam logic [1:0] TRATE_SLOW = 2'h0;
  localparam logic [1:0] TRATE_FAST = 2'h1;
  localparam logic [1:0] TRATE_DC = 2'h3;
  localparam logic [7:0] ROUTE_NONE = 8'h00;
  localparam logic [7:0] SUPPLY_QUARTER_MASK = 8'h0c;

  typedef enum logic [1:0] {
    DEC_IDLE = 2'b01,
    DEC_RUN = 2'b10
  } csd_dec_e;
endpackage

// ==== hw/csd_fifo.sv ====
// synchronous fifo with valid/ready on both sides
// assumes a single clock and a synchronous active-low reset
`timescale 1ns/1ps
module csd_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  input wire logic clk, // clock
  input wire logic rst_b, // sync reset, active low
  input wire logic in_valid, // push request
  output logic in_ready, // room for a word
  input wire logic [W-1:0] in_data, // pushed word
  output logic out_valid, // word available
  input wire logic out_ready, // consumer takes word
  output logic [W-1:0] out_data, // oldest word
  output logic full, // no room
  output logic empty // nothing held
);
  localparam int AW = $clog2(D);

  logic [W-1:0] mem [D];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  assign full = (cnt_q == (AW+1)'(D));
  assign empty = (cnt_q == '0);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[rd_ptr_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // ---------------------------------------------------------------------------
  // pointers and storage
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == AW'(D-1)) ? '0 : wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == AW'(D-1)) ? '0 : rd_ptr_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

  // storage needs no reset; empty guards stale words
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_q] <= in_data;
    end
  end

  fifo_bound_a: assert property (@(posedge clk) disable iff (!rst_b) full |-> !push)
    else $error("fifo accepted a word while full");
endmodule // csd_fifo

// ==== hw/csd_top.sv ====
// channel input routing, test signal source and per-channel sinc3 decimators
// assumes modulator bits arrive asynchronously and the register master obeys one-cycle strobes
//
// Contract
// - select 001 shorts inputs to mid-reference
// - select 101 routes internal test signals
// - test amplitude and toggle rate from config
// - select 011 supply monitor; channels 3,4 quarter
// - select 010 plus bias measure measures bias
// - seven gains per channel settings register
// - each channel own 24-bit second-order converter
// - modulator and filter run at half clock
// - each channel has own sinc3 decimator
// - one global rate field for all
// - response is cubed moving-sum of length N
// - bitstream decimated into parallel words
// - reference buffer powerdown bit, reset external
// - 000 normal, 110/111 bias return pos/neg
// - device clock from 2.048 MHz oscillator; this design assumes a 20 MHz clock
// - settled only after three output periods
//
// The address-and-strobe port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module csd_top #(
  parameter int TEST_DIV_SLOW = csd_pkg::TEST_DIV_SLOW,
  parameter int TEST_DIV_FAST = csd_pkg::TEST_DIV_FAST
) (
  input wire logic clk, // device clock
  input wire logic rst_b, // sync reset, active low
  input wire logic [4:0] reg_addr, // register address
  input wire logic [7:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [7:0] reg_rdata, // read data, cycle after strobe
  input wire logic [7:0] mod_bit, // modulator bitstreams, async
  output logic [63:0] ch_route, // per channel one-hot switch set, all zero for select 010 without bias measure
  output logic [23:0] pga_gain_code, // per channel gain code
  output logic [7:0] supply_quarter, // supply monitor uses quarter digital supply
  output logic test_signal_pos, // test signal, positive side
  output logic test_signal_neg, // test signal, negative side
  output logic test_amplitude_select_high, // test amplitude select
  output logic refbuf_powerdown, // reference buffer off
  output logic conv_valid, // one-cycle result strobe
  output logic [191:0] conv_data, // all channel results
  output logic conv_settled, // three periods since change
  output logic out_valid, // buffered result ready
  input wire logic out_ready, // consumer takes result
  output logic [191:0] out_data // buffered results
);
  localparam logic [20:0] HALF_SLOW_M1 = 21'(TEST_DIV_SLOW / 2 - 1);
  localparam logic [20:0] HALF_FAST_M1 = 21'(TEST_DIV_FAST / 2 - 1);

  typedef struct packed {
    logic [7:0][7:0] chset;
    logic [2:0] rate;
    logic [2:0] tcfg;
    logic refbuf_pd;
    logic bias_measure_enable;
    logic [7:0] rdata;
    logic overrun;
    logic [7:0] sync1;
    logic [7:0] sync2;
    logic mod_phase;
    logic [7:0][39:0] i1;
    logic [7:0][39:0] i2;
    logic [7:0][39:0] i3;
    logic [7:0][39:0] d1;
    logic [7:0][39:0] d2;
    logic [7:0][39:0] d3;
    logic [11:0] dcnt;
    csd_pkg::csd_dec_e dec;
    logic [7:0][23:0] word;
    logic conv_valid;
    logic [1:0] settle;
    logic [7:0][7:0] route;
    logic [7:0] quarter;
    logic [20:0] tcnt;
    logic tlevel;
  } csd_state_s;

  csd_state_s q;
  csd_state_s n;
  logic push_ready;
  logic fifo_full;
  logic fifo_empty;

  // ---------------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------------
  // last count of a decimation period: 2^(6+code) - 1
  function automatic logic [11:0] ratio_last(input logic [2:0] code);
    logic [3:0] k;
    k = csd_pkg::RATIO_LOG2_BASE + {1'b0, code};
    return 12'((13'h1 << k) - 13'h1);
  endfunction

  // full scale is +-N^3; bring it to 24 bits and saturate the +N^3 corner
  function automatic logic [23:0] to_word(input logic signed [39:0] c, input logic [2:0] code);
    logic signed [63:0] w;
    logic [5:0] sh;
    logic [3:0] k;
    k = csd_pkg::RATIO_LOG2_BASE + {1'b0, code};
    sh = {2'b00, k} + {1'b0, k, 1'b0};
    // signed cast keeps the right shift arithmetic for negative sums
    w = ($signed({{24{c[39]}}, c}) <<< 23) >>> sh;
    if (w > 64'sh7fffff) begin
      return 24'h7fffff;
    end else if (w < -64'sh800000) begin
      return 24'h800000;
    end
    return w[23:0];
  endfunction

  // ---------------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------------
  always_comb begin
    logic restart;
    logic [2:0] sel;
    logic [2:0] gain;
    logic signed [39:0] x;
    logic signed [39:0] c1;
    logic signed [39:0] c2;
    logic signed [39:0] c3;
    restart = 1'b0;
    sel = '0;
    gain = '0;
    x = '0;
    c1 = '0;
    c2 = '0;
    c3 = '0;
    n = q;
    n.rdata = '0;
    n.conv_valid = 1'b0;
    n.sync1 = mod_bit;
    n.sync2 = q.sync1;
    n.mod_phase = !q.mod_phase;

    // register writes
    if (reg_wr) begin
      if (reg_addr < csd_pkg::ADDR_CFG_A) begin
        gain = reg_wdata[csd_pkg::CH_GAIN_LSB +: 3];
        if (gain == csd_pkg::GAIN_INVALID) begin
          gain = '0;
        end
        n.chset[reg_addr[2:0]] = {reg_wdata[7], gain, reg_wdata[3:0]};
        n.settle = '0;
      end else if (reg_addr == csd_pkg::ADDR_CFG_A) begin
        n.rate = reg_wdata[2:0];
        restart = 1'b1;
      end else if (reg_addr == csd_pkg::ADDR_CFG_B) begin
        n.tcfg = reg_wdata[2:0];
      end else if (reg_addr == csd_pkg::ADDR_CFG_C) begin
        n.refbuf_pd = reg_wdata[csd_pkg::CFGC_REFPD_BIT];
        n.bias_measure_enable = reg_wdata[csd_pkg::CFGC_BIASM_BIT];
      end else if (reg_addr == csd_pkg::ADDR_STATUS) begin
        if (reg_wdata[csd_pkg::ST_OVERRUN_BIT]) begin
          n.overrun = 1'b0;
        end
      end
    end

    // register reads; unmapped offsets read zero
    if (reg_rd) begin
      if (reg_addr < csd_pkg::ADDR_CFG_A) begin
        n.rdata = q.chset[reg_addr[2:0]];
      end else if (reg_addr == csd_pkg::ADDR_CFG_A) begin
        n.rdata = {5'h00, q.rate};
      end else if (reg_addr == csd_pkg::ADDR_CFG_B) begin
        n.rdata = {5'h00, q.tcfg};
      end else if (reg_addr == csd_pkg::ADDR_CFG_C) begin
        n.rdata[csd_pkg::CFGC_REFPD_BIT] = q.refbuf_pd;
        n.rdata[csd_pkg::CFGC_BIASM_BIT] = q.bias_measure_enable;
      end else if (reg_addr == csd_pkg::ADDR_STATUS) begin
        n.rdata[csd_pkg::ST_SETTLED_BIT] = (q.settle == csd_pkg::SETTLE_PERIODS);
        n.rdata[csd_pkg::ST_RATEINV_BIT] = (q.rate == csd_pkg::RATE_INVALID);
        n.rdata[csd_pkg::ST_OVERRUN_BIT] = q.overrun;
        n.rdata[csd_pkg::ST_EMPTY_BIT] = fifo_empty;
        n.rdata[csd_pkg::ST_FULL_BIT] = fifo_full;
      end
    end

    // test source: free square wave or dc level
    if (q.tcfg[1:0] == csd_pkg::TRATE_DC) begin
      n.tlevel = 1'b1;
      n.tcnt = '0;
    end else if (q.tcfg[1:0] == csd_pkg::TRATE_SLOW || q.tcfg[1:0] == csd_pkg::TRATE_FAST) begin
      if (q.tcnt >= ((q.tcfg[1:0] == csd_pkg::TRATE_SLOW) ? HALF_SLOW_M1 : HALF_FAST_M1)) begin
        n.tcnt = '0;
        n.tlevel = !q.tlevel;
      end else begin
        n.tcnt = q.tcnt + 21'h1;
      end
    end

    // input switch set per channel
    for (int c = 0; c < csd_pkg::NCH; c++) begin
      sel = q.chset[c][csd_pkg::CH_SEL_LSB +: 3];
      n.route[c] = csd_pkg::ROUTE_NONE;
      n.quarter[c] = 1'b0;
      case (sel)
        csd_pkg::SEL_NORMAL: n.route[c][0] = 1'b1;
        csd_pkg::SEL_SHORT: n.route[c][1] = 1'b1;
        csd_pkg::SEL_BIAS_MEASURE_ENABLE: n.route[c][2] = q.bias_measure_enable;
        csd_pkg::SEL_SUPPLY: begin
          n.route[c][3] = 1'b1;
          n.quarter[c] = csd_pkg::SUPPLY_QUARTER_MASK[c];
        end
        csd_pkg::SEL_TEMP: n.route[c][4] = 1'b1;
        csd_pkg::SEL_TEST: n.route[c][5] = 1'b1;
        csd_pkg::SEL_BIAS_POS: n.route[c][6] = 1'b1;
        default: n.route[c][7] = 1'b1;
      endcase
    end

    // sinc3 decimators, one per channel, fed at half the clock rate
    case (q.dec)
      csd_pkg::DEC_IDLE: begin
        n.i1 = '0;
        n.i2 = '0;
        n.i3 = '0;
        n.d1 = '0;
        n.d2 = '0;
        n.d3 = '0;
        n.dcnt = '0;
        if (q.rate != csd_pkg::RATE_INVALID) begin
          n.dec = csd_pkg::DEC_RUN;
        end
      end
      csd_pkg::DEC_RUN: begin
        if (q.mod_phase) begin
          for (int c = 0; c < csd_pkg::NCH; c++) begin
            x = q.sync2[c] ? 40'sh1 : -40'sh1;
            n.i1[c] = q.i1[c] + x;
            n.i2[c] = q.i2[c] + q.i1[c];
            n.i3[c] = q.i3[c] + q.i2[c];
            if (q.dcnt == ratio_last(q.rate)) begin
              c1 = q.i3[c] - q.d1[c];
              c2 = c1 - q.d2[c];
              c3 = c2 - q.d3[c];
              n.d1[c] = q.i3[c];
              n.d2[c] = c1;
              n.d3[c] = c2;
              n.word[c] = to_word(c3, q.rate);
            end
          end
          if (q.dcnt == ratio_last(q.rate)) begin
            n.dcnt = '0;
            n.conv_valid = 1'b1;
            if (q.settle != csd_pkg::SETTLE_PERIODS && !(reg_wr && reg_addr < csd_pkg::ADDR_CFG_A)) begin
              n.settle = q.settle + 2'h1;
            end
          end else begin
            n.dcnt = q.dcnt + 12'h1;
          end
        end
      end
      default: n.dec = csd_pkg::DEC_IDLE;
    endcase

    if (restart) begin
      n.dec = csd_pkg::DEC_IDLE;
      n.settle = '0;
    end

    // a lost result wins over a clear in the same cycle
    if (q.conv_valid && !push_ready) begin
      n.overrun = 1'b1;
    end
  end

  // ---------------------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      q <= '0;
      q.chset <= {csd_pkg::NCH{csd_pkg::CHSET_RST}};
      q.rate <= csd_pkg::RATE_RST;
      q.tcfg <= csd_pkg::TCFG_RST;
      q.refbuf_pd <= csd_pkg::REFPD_RST;
      q.bias_measure_enable <= csd_pkg::BIASM_RST;
      q.dec <= csd_pkg::DEC_IDLE;
    end else begin
      q <= n;
    end
  end

  // ---------------------------------------------------------------------------
  // result buffer
  // ---------------------------------------------------------------------------
  csd_fifo #(
    .W(192),
    .D(csd_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_b(rst_b),
    .in_valid(q.conv_valid),
    .in_ready(push_ready),
    .in_data(q.word),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data(out_data),
    .full(fifo_full),
    .empty(fifo_empty)
  );

  assign reg_rdata = q.rdata;
  assign ch_route = q.route;
  assign supply_quarter = q.quarter;
  assign test_signal_pos = q.tlevel;
  assign test_signal_neg = !q.tlevel;
  assign test_amplitude_select_high = q.tcfg[csd_pkg::CFGB_AMP_BIT];
  assign refbuf_powerdown = q.refbuf_pd;
  assign conv_valid = q.conv_valid;
  assign conv_data = q.word;
  assign conv_settled = (q.settle == csd_pkg::SETTLE_PERIODS);
  for (genvar g = 0; g < csd_pkg::NCH; g++) begin : g_gain
    assign pga_gain_code[g*3 +: 3] = q.chset[g][csd_pkg::CH_GAIN_LSB +: 3];
  end

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  logic [13:0] gap_q;
  logic gap_armed_q;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      gap_q <= '0;
      gap_armed_q <= 1'b0;
    end else begin
      gap_q <= conv_valid ? 14'h0 : gap_q + 14'h1;
      gap_armed_q <= (reg_wr && reg_addr == csd_pkg::ADDR_CFG_A) ? 1'b0 : (gap_armed_q || conv_valid);
    end
  end

  sequence ch0_wr_s(logic [2:0] code);
    reg_wr && reg_addr == csd_pkg::ADDR_CHSET0 && reg_wdata[2:0] == code;
  endsequence
  sequence ch0_quiet_s;
    !(reg_wr && reg_addr == csd_pkg::ADDR_CHSET0);
  endsequence

  short_route_a: assert property (@(posedge clk) disable iff (!rst_b)
    ch0_wr_s(csd_pkg::SEL_SHORT) ##1 ch0_quiet_s |=> ch_route[7:0] == 8'h02)
    else $error("shorted select did not route mid-reference");
  test_route_a: assert property (@(posedge clk) disable iff (!rst_b)
    ch0_wr_s(csd_pkg::SEL_TEST) ##1 ch0_quiet_s |=> ch_route[7:0] == 8'h20)
    else $error("test select did not route test signals");
  supply_quarter_a: assert property (@(posedge clk) disable iff (!rst_b)
    supply_quarter[2] == ch_route[19] && !supply_quarter[0])
    else $error("supply monitor divider wrong for channel");
  bias_measure_enable_a: assert property (@(posedge clk) disable iff (!rst_b)
    ch_route[2] |-> $past(q.bias_measure_enable) && $past(q.chset[0][2:0]) == csd_pkg::SEL_BIAS_MEASURE_ENABLE)
    else $error("bias measure routed without its enable");
  gain_code_a: assert property (@(posedge clk) disable iff (!rst_b)
    pga_gain_code[2:0] != csd_pkg::GAIN_INVALID)
    else $error("channel gain holds an unused code");
  refbuf_reset_a: assert property (@(posedge clk) $rose(rst_b) |-> refbuf_powerdown)
    else $error("reference buffer not in external mode after reset");
  conv_pulse_a: assert property (@(posedge clk) disable iff (!rst_b)
    conv_valid |=> !conv_valid[*2])
    else $error("result strobe longer than one cycle");
  cadence_a: assert property (@(posedge clk) disable iff (!rst_b)
    (conv_valid && gap_armed_q) |-> gap_q == 14'({ratio_last(q.rate), 1'b1}))
    else $error("result spacing differs from twice the ratio");
  settle_a: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(conv_settled) |-> conv_valid)
    else $error("settled flag rose outside a result");
endmodule // csd_top

// ==== sim/csd_mod_model.sv ====
// modulator bitstream source standing in for the analog front end
// assumes the bench picks the pattern; bits move only on rising clk
`timescale 1ns/1ps
module csd_mod_model (
  input wire logic clk, // device clock
  input wire logic [1:0] mode, // 0 low, 1 high, 2 alternating
  output logic [7:0] mod_bit // one bit per channel
);
  logic ph_q;
  initial ph_q = 1'b0;
  initial mod_bit = 8'h00;
  // new sample every second clock: modulator runs at half rate
  always @(posedge clk) begin
    ph_q <= ~ph_q;
    if (ph_q) begin
      case (mode)
        2'h0: mod_bit <= 8'h00;
        2'h1: mod_bit <= 8'hff;
        default: mod_bit <= ~mod_bit;
      endcase
    end
  end
endmodule // csd_mod_model

// ==== sim/tb_channel_select_sinc3_decimator.sv ====
// self-checking bench for csd_top with a modulator source model
// assumes 20 MHz clock and shortened test signal dividers
`timescale 1ns/1ps
module tb_channel_select_sinc3_decimator;
  logic clk, rst_b, reg_wr, reg_rd, out_ready, rd_d, b;
  logic [4:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, mod_bit, supply_quarter, m;
  logic [63:0] ch_route;
  logic [23:0] pga_gain_code;
  logic test_signal_pos, test_signal_neg, test_amplitude_select_high, refbuf_powerdown, conv_valid, conv_settled, out_valid;
  logic [191:0] conv_data, out_data;
  logic [1:0] mode;
  logic [7:0] q_exp[$], q_msk[$];
  logic [191:0] q_cv[$];
  int n_errors, checks, ch, cnt, e;

  csd_mod_model fe (.clk(clk), .mode(mode), .mod_bit(mod_bit));
  csd_top #(.TEST_DIV_SLOW(16), .TEST_DIV_FAST(8)) dut (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mod_bit(mod_bit),
    .ch_route(ch_route), .pga_gain_code(pga_gain_code), .supply_quarter(supply_quarter),
    .test_signal_pos(test_signal_pos), .test_signal_neg(test_signal_neg), .test_amplitude_select_high(test_amplitude_select_high),
    .refbuf_powerdown(refbuf_powerdown), .conv_valid(conv_valid), .conv_data(conv_data),
    .conv_settled(conv_settled), .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data));

  // ---------------------------------------------------------------
  // compare, bus and wait tasks
  // ---------------------------------------------------------------
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp192(input logic [191:0] got, input logic [191:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("errors=%0d checks=%0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // expected byte is queued; the watcher below judges it next cycle
  task automatic rd(input logic [4:0] a, input logic [7:0] exp, input logic [7:0] msk);
    @(posedge clk);
    q_exp.push_back(exp);
    q_msk.push_back(msk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask
  task automatic wait_conv(input int lim);
    cnt = 0;
    do begin
      @(posedge clk);
      cnt++;
    end while (conv_valid !== 1'b1 && cnt < lim);
    if (conv_valid !== 1'b1) begin
      n_errors++;
      wrap_up();
    end
  endtask

  always @(posedge clk) begin
    if (rd_d === 1'b1 && q_exp.size() > 0) begin
      m = q_msk.pop_front();
      cmp({24'h0, reg_rdata & m}, {24'h0, q_exp.pop_front() & m});
    end
    if (conv_valid === 1'b1 && q_cv.size() > 0) cmp192(conv_data, q_cv.pop_front());
    rd_d <= reg_rd;
  end

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    rst_b = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 5'h00; reg_wdata = 8'h00;
    out_ready = 1'b0; mode = 2'h1; rd_d = 1'b0; n_errors = 0; checks = 0;
    void'($urandom(16));
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    rd(csd_pkg::ADDR_CFG_A, 8'h06, 8'h07);
    rd(csd_pkg::ADDR_CFG_C, 8'h80, 8'h90);
    cmp({31'h0, refbuf_powerdown}, 32'h1);
    rd(5'h1f, 8'h00, 8'hff);
    for (int bm = 0; bm < 2; bm++) begin
      wr(csd_pkg::ADDR_CFG_C, bm[0] ? 8'h10 : 8'h00);
      for (int s = 0; s < 8; s++) begin
        // second pass pins channel 0, and channel 2 for supply, so route checks fire
        ch = bm[0] ? ((s == 3) ? 2 : 0) : ($urandom % 8);
        // gain code 0 keeps a supply reading out of saturation
        wr(csd_pkg::ADDR_CHSET0 + 5'(ch), {5'h00, 3'(s)});
        repeat (3) @(posedge clk);
        e = (s == 2 && bm == 0) ? 0 : (1 << s);
        cmp({24'h0, ch_route[ch*8 +: 8]}, 32'(e));
        e = (s == 3 && (ch == 2 || ch == 3)) ? 1 : 0;
        cmp({31'h0, supply_quarter[ch]}, 32'(e));
      end
    end
    cmp({31'h0, refbuf_powerdown}, 32'h0);
    for (int g = 0; g < 8; g++) begin
      wr(csd_pkg::ADDR_CHSET0 + 5'(ch), {1'b0, 3'(g), 4'h0});
      rd(csd_pkg::ADDR_CHSET0 + 5'(ch), (g == 7) ? 8'h00 : 8'(g << 4), 8'h70);
      cmp({29'h0, pga_gain_code[3*ch +: 3]}, (g == 7) ? 32'h0 : 32'(g));
    end
    wr(csd_pkg::ADDR_CFG_B, 8'h05);
    repeat (3) @(posedge clk);
    cmp({30'h0, test_amplitude_select_high, test_signal_neg ^ test_signal_pos}, 32'h3);
    for (int k = 0; k < 2; k++) begin
      b = test_signal_pos;
      cnt = 0;
      while (test_signal_pos === b && cnt < 20) begin
        @(posedge clk);
        cnt++;
      end
      if (cnt >= 20) begin
        n_errors++;
        wrap_up();
      end
    end
    cmp(32'(cnt), 32'h4);
    wr(csd_pkg::ADDR_CFG_B, 8'h03);
    repeat (3) @(posedge clk);
    cmp({30'h0, test_amplitude_select_high, test_signal_pos}, 32'h1);
    for (int r = 0; r < 3; r++) begin
      wr(csd_pkg::ADDR_CFG_A, 8'(r));
      wait_conv(1200);
      wait_conv(1200);
      cmp(32'(cnt), 32'(128 << r));
    end
    wr(csd_pkg::ADDR_CFG_A, 8'h00);
    for (int p = 0; p < 2; p++) begin
      mode <= p[0] ? 2'h0 : 2'h1;
      repeat (4) wait_conv(300);
      // push off a strobe edge so the watcher cannot take it one result early
      @(posedge clk);
      q_cv.push_back(p[0] ? {8{24'h800000}} : {8{24'h7fffff}});
      wait_conv(300);
      cmp({31'h0, conv_settled}, 32'h1);
    end
    // sixteen results fill the buffer; this seventeenth one is lost
    wait_conv(300);
    rd(csd_pkg::ADDR_STATUS, 8'h14, 8'h1c);
    wr(csd_pkg::ADDR_STATUS, 8'h04);
    rd(csd_pkg::ADDR_STATUS, 8'h00, 8'h04);
    out_ready <= 1'b1;
    repeat (15) @(posedge clk);
    out_ready <= 1'b0;
    @(posedge clk);
    cmp192(out_data, {8{24'h800000}});
    cmp({31'h0, out_valid}, 32'h1);
    out_ready <= 1'b1;
    repeat (2) @(posedge clk);
    rd(csd_pkg::ADDR_STATUS, 8'h08, 8'h18);
    wr(csd_pkg::ADDR_CFG_A, 8'h07);
    rd(csd_pkg::ADDR_STATUS, 8'h02, 8'h02);
    cnt = 0;
    repeat (600) begin
      @(posedge clk);
      if (conv_valid !== 1'b0) cnt++;
    end
    cmp(32'(cnt), 32'h0);
    repeat (3) @(posedge clk);
    wrap_up();
  end
endmodule // tb_channel_select_sinc3_decimator
